// ---- logic/cabe_core.sv ----
// Execution core for arithmetic, logic, shift, skip, branch, call and return operations.
// Assumes the register file, I/O space and stack sit outside and answer through the request.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module cabe_core (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               req_valid,
  input  wire cabe_pkg::cabe_req_t req,
  output logic                    req_ready,
  output logic                    done,
  output cabe_pkg::cabe_res_t     res,
  output logic [15:0]             pc,
  output logic [7:0]              flags,
  input  wire logic [1:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [7:0]              reg_rdata
);
  import cabe_pkg::*;

  cabe_state_t state_reg;
  logic [2:0]  cnt_reg;
  logic        done_reg;
  logic [7:0]  flags_reg;
  logic [7:0]  flags_next;
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  cabe_res_t   res_reg;
  cabe_res_t   res_next;
  logic [7:0]  result_reg;
  logic [7:0]  result_next;
  logic [7:0]  rdata_reg;
  logic [2:0]  cyc;
  logic        issue;

  logic [7:0]  a;
  logic [7:0]  opb;
  logic        cin;
  logic [7:0]  add_r;
  logic [7:0]  sub_r;
  logic        add_h;
  logic        add_v;
  logic        add_c;
  logic        sub_h;
  logic        sub_v;
  logic        sub_c;
  logic [15:0] wsum;
  logic [15:0] wdiff;
  logic [15:0] pc_inc;
  logic [15:0] pc_rel;
  logic [15:0] pc_skip;
  logic [2:0]  cyc_skip;
  logic        br_take;
  logic [7:0]  one_hot_bit;

  assign issue     = req_valid && req_ready;
  assign req_ready = (state_reg == ST_IDLE);
  assign done      = done_reg;
  assign res       = res_reg;
  assign pc        = pc_reg;
  assign flags     = flags_reg;
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection and shared arithmetic
  always_comb begin
    a   = req.a;
    opb = req.b;
    cin = 1'b0;
    unique case (req.op)
      OP_MINUS_IMMEDIATE, OP_MASK_WITH_IMMEDIATE, OP_MERGE_IMMEDIATE_BITS, OP_COMPARE_IMMEDIATE,
      OP_SET_MASK_BITS:
        opb = req.imm;
      OP_MINUS_IMMEDIATE_BORROW: begin
        opb = req.imm;
        cin = flags_reg[FL_C];
      end
      OP_CLEAR_MASK_BITS:
        opb = 8'hff - req.imm;
      OP_ZERO_SIGN_CHECK, OP_CLEAR:
        opb = req.a;
      OP_ADD_CARRY, OP_MINUS_WITH_BORROW, OP_COMPARE_REGS_CARRY:
        cin = flags_reg[FL_C];
      default: ;
    endcase
  end

  assign add_r = a + opb + {7'h00, cin};
  assign sub_r = a - opb - {7'h00, cin};
  assign add_h = (a[3] & opb[3]) | (opb[3] & ~add_r[3]) | (~add_r[3] & a[3]);
  assign add_v = (a[7] & opb[7] & ~add_r[7]) | (~a[7] & ~opb[7] & add_r[7]);
  assign add_c = (a[7] & opb[7]) | (opb[7] & ~add_r[7]) | (~add_r[7] & a[7]);
  assign sub_h = (~a[3] & opb[3]) | (opb[3] & sub_r[3]) | (sub_r[3] & ~a[3]);
  assign sub_v = (a[7] & ~opb[7] & ~sub_r[7]) | (~a[7] & opb[7] & sub_r[7]);
  assign sub_c = (~a[7] & opb[7]) | (opb[7] & sub_r[7]) | (sub_r[7] & ~a[7]);

  assign wsum    = req.word + {10'h000, req.imm[5:0]};
  assign wdiff   = req.word - {10'h000, req.imm[5:0]};
  assign pc_inc  = pc_reg + 16'h0001;
  assign pc_rel  = pc_reg + {{4{req.offs[11]}}, req.offs} + 16'h0001;
  assign pc_skip = req.long_next ? pc_reg + 16'h0003 : pc_reg + 16'h0002;
  assign cyc_skip = req.long_next ? CYC_THREE : CYC_TWO;
  assign one_hot_bit = 8'h01 << req.bsel;

  ////////////////////////////////////////////////////////////////////////////
  // Branch condition
  always_comb begin
    unique case (req.op)
      OP_BRANCH_FLAG_SET:        br_take = flags_reg[req.bsel];
      OP_BRANCH_FLAG_CLEAR:      br_take = ~flags_reg[req.bsel];
      OP_BRANCH_EQUAL:           br_take = flags_reg[FL_Z];
      OP_BRANCH_NOT_EQUAL:       br_take = ~flags_reg[FL_Z];
      OP_BRANCH_CARRY_SET,
      OP_BRANCH_LOWER:           br_take = flags_reg[FL_C];
      OP_BRANCH_CARRY_CLEAR,
      OP_BRANCH_SAME_HIGHER:     br_take = ~flags_reg[FL_C];
      OP_BRANCH_MINUS:           br_take = flags_reg[FL_N];
      OP_BRANCH_PLUS:            br_take = ~flags_reg[FL_N];
      OP_BRANCH_SIGNED_AT_LEAST: br_take = ~(flags_reg[FL_N] ^ flags_reg[FL_V]);
      OP_BRANCH_SIGNED_LESS:     br_take = flags_reg[FL_N] ^ flags_reg[FL_V];
      OP_BRANCH_HALFCARRY_SET:   br_take = flags_reg[FL_H];
      OP_BRANCH_HALFCARRY_CLEAR: br_take = ~flags_reg[FL_H];
      OP_BRANCH_TFLAG_SET:       br_take = flags_reg[FL_T];
      OP_BRANCH_TFLAG_CLEAR:     br_take = ~flags_reg[FL_T];
      OP_BRANCH_OVERFLOW_SET:    br_take = flags_reg[FL_V];
      OP_BRANCH_OVERFLOW_CLEAR:  br_take = ~flags_reg[FL_V];
      OP_BRANCH_IRQ_ON:          br_take = flags_reg[FL_I];
      OP_BRANCH_IRQ_OFF:         br_take = ~flags_reg[FL_I];
      default:                   br_take = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execution: result, flags, program counter and cycle count
  always_comb begin
    res_next    = '0;
    flags_next  = flags_reg;
    pc_next     = pc_inc;
    cyc         = CYC_ONE;
    result_next = result_reg;
    unique case (req.op)
      OP_ADD, OP_ADD_CARRY: begin
        result_next        = add_r;
        flags_next[FL_H]   = add_h;
        flags_next[FL_V]   = add_v;
        flags_next[FL_C]   = add_c;
        flags_next[FL_N]   = add_r[7];
        flags_next[FL_Z]   = (add_r == 8'h00);
        flags_next[FL_S]   = add_r[7] ^ add_v;
        res_next.wr_en     = 1'b1;
        res_next.wr_data   = add_r;
      end
      OP_SUBTRACT, OP_MINUS_IMMEDIATE, OP_MINUS_WITH_BORROW, OP_MINUS_IMMEDIATE_BORROW,
      OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE: begin
        flags_next[FL_H]   = sub_h;
        flags_next[FL_V]   = sub_v;
        flags_next[FL_C]   = sub_c;
        flags_next[FL_N]   = sub_r[7];
        flags_next[FL_S]   = sub_r[7] ^ sub_v;
        // Borrow forms keep a multi-byte zero chain
        if (req.op inside {OP_MINUS_WITH_BORROW, OP_MINUS_IMMEDIATE_BORROW, OP_COMPARE_REGS_CARRY}) begin
          flags_next[FL_Z] = (sub_r == 8'h00) & flags_reg[FL_Z];
        end else begin
          flags_next[FL_Z] = (sub_r == 8'h00);
        end
        if (!(req.op inside {OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE})) begin
          result_next      = sub_r;
          res_next.wr_en   = 1'b1;
          res_next.wr_data = sub_r;
        end
      end
      OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
        cyc = CYC_TWO;
        if (req.op == OP_WORD_PLUS_IMMEDIATE) begin
          res_next.word_data = wsum;
          flags_next[FL_V]   = ~req.word[15] & wsum[15];
          flags_next[FL_C]   = req.word[15] & ~wsum[15];
        end else begin
          res_next.word_data = wdiff;
          flags_next[FL_V]   = req.word[15] & ~wdiff[15];
          flags_next[FL_C]   = ~req.word[15] & wdiff[15];
        end
        res_next.word_wr_en = 1'b1;
        flags_next[FL_N]    = res_next.word_data[15];
        flags_next[FL_Z]    = (res_next.word_data == 16'h0000);
        flags_next[FL_S]    = flags_next[FL_N] ^ flags_next[FL_V];
        result_next         = res_next.word_data[7:0];
      end
      OP_AND, OP_MASK_WITH_IMMEDIATE, OP_ZERO_SIGN_CHECK, OP_CLEAR_MASK_BITS, OP_OR,
      OP_MERGE_IMMEDIATE_BITS, OP_SET_MASK_BITS, OP_EXCLUSIVE_OR_REGISTERS, OP_CLEAR: begin
        if (req.op inside {OP_OR, OP_MERGE_IMMEDIATE_BITS, OP_SET_MASK_BITS}) begin
          result_next = a | opb;
        end else if (req.op inside {OP_EXCLUSIVE_OR_REGISTERS, OP_CLEAR}) begin
          result_next = a ^ opb;
        end else begin
          result_next = a & opb;
        end
        flags_next[FL_V] = 1'b0;
        flags_next[FL_N] = result_next[7];
        flags_next[FL_Z] = (result_next == 8'h00);
        res_next.wr_en   = 1'b1;
        res_next.wr_data = result_next;
      end
      OP_INVERT_BITS, OP_ARITH_INVERT, OP_INCREMENT, OP_DECREMENT: begin
        unique case (req.op)
          OP_INVERT_BITS: begin
            result_next      = 8'hff - a;
            flags_next[FL_C] = 1'b1;
            flags_next[FL_V] = 1'b0;
          end
          OP_ARITH_INVERT: begin
            result_next      = 8'h00 - a;
            flags_next[FL_C] = (result_next != 8'h00);
            flags_next[FL_V] = (result_next == 8'h80);
            flags_next[FL_H] = result_next[3] | a[3];
          end
          OP_INCREMENT: begin
            result_next      = a + 8'h01;
            flags_next[FL_V] = (result_next == 8'h80);
          end
          default: begin
            result_next      = a - 8'h01;
            flags_next[FL_V] = (result_next == 8'h7f);
          end
        endcase
        flags_next[FL_N] = result_next[7];
        flags_next[FL_Z] = (result_next == 8'h00);
        if (!(req.op inside {OP_INCREMENT, OP_DECREMENT})) begin
          flags_next[FL_S] = result_next[7] ^ flags_next[FL_V];
        end
        res_next.wr_en   = 1'b1;
        res_next.wr_data = result_next;
      end
      OP_FILL_ONES: begin
        result_next      = 8'hff;
        res_next.wr_en   = 1'b1;
        res_next.wr_data = 8'hff;
      end
      OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY: begin
        if (req.op == OP_SHIFT_RIGHT_LOGICAL) begin
          result_next      = {1'b0, a[7:1]};
          flags_next[FL_C] = a[0];
        end else begin
          result_next      = {a[6:0], (req.op == OP_ROTATE_LEFT_CARRY) & flags_reg[FL_C]};
          flags_next[FL_C] = a[7];
        end
        flags_next[FL_N] = result_next[7];
        flags_next[FL_Z] = (result_next == 8'h00);
        flags_next[FL_V] = result_next[7] ^ flags_next[FL_C];
        flags_next[FL_S] = flags_next[FL_C];
        res_next.wr_en   = 1'b1;
        res_next.wr_data = result_next;
      end
      OP_RELATIVE_JUMP: begin
        pc_next = pc_rel;
        cyc     = CYC_TWO;
      end
      OP_POINTER_JUMP: begin
        pc_next = req.zptr;
        cyc     = CYC_TWO;
      end
      OP_RELATIVE_CALL, OP_POINTER_CALL: begin
        pc_next            = (req.op == OP_POINTER_CALL) ? req.zptr : pc_rel;
        cyc                = CYC_THREE;
        res_next.push_en   = 1'b1;
        res_next.push_data = pc_inc;
      end
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
        pc_next         = req.stack;
        cyc             = CYC_FOUR;
        res_next.pop_en = 1'b1;
        if (req.op == OP_INTERRUPT_EXIT) begin
          flags_next[FL_I] = 1'b1;
        end
      end
      OP_EQUAL_SKIP, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR,
      OP_SKIP_IO_BIT_SET: begin
        if ((req.op == OP_EQUAL_SKIP && req.a == req.b) ||
            (req.op == OP_SKIP_REG_BIT_CLEAR && !req.b[req.bsel]) ||
            (req.op == OP_SKIP_REG_BIT_SET && req.b[req.bsel]) ||
            (req.op == OP_SKIP_IO_BIT_CLEAR && !req.io[req.bsel]) ||
            (req.op == OP_SKIP_IO_BIT_SET && req.io[req.bsel])) begin
          pc_next = pc_skip;
          cyc     = cyc_skip;
        end
      end
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
        cyc               = CYC_TWO;
        res_next.io_wr_en = 1'b1;
        res_next.io_data  = (req.op == OP_IO_BIT_SET) ? (req.io | one_hot_bit) : (req.io & ~one_hot_bit);
      end
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
      OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
      OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_AT_LEAST, OP_BRANCH_SIGNED_LESS,
      OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TFLAG_SET,
      OP_BRANCH_TFLAG_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
      OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
        if (br_take) begin
          pc_next = pc_rel;
          cyc     = CYC_TWO;
        end
      end
      default: ;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Occupancy: ready drops for the extra cycles, done marks the end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 3'h0;
      done_reg  <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (issue) begin
            if (cyc == CYC_ONE) begin
              done_reg <= 1'b1;
            end else begin
              state_reg <= ST_BUSY;
              cnt_reg   <= cyc - CYC_ONE;
            end
          end
        end
        ST_BUSY: begin
          cnt_reg <= cnt_reg - 3'h1;
          if (cnt_reg == 3'h1) begin
            state_reg <= ST_IDLE;
            done_reg  <= 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Instruction flag updates win over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_reg <= FLAGS_RST;
    end else if (issue) begin
      flags_reg <= flags_next;
    end else if (reg_wr && reg_addr == REG_FLAGS) begin
      flags_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_reg <= PC_RST;
    end else if (issue) begin
      pc_reg <= pc_next;
    end
  end

  // Result strobes last one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_reg    <= '0;
      result_reg <= 8'h00;
    end else begin
      res_reg <= issue ? res_next : '0;
      if (issue) begin
        result_reg <= result_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port read path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_FLAGS:  rdata_reg <= flags_reg;
        REG_PC_LO:  rdata_reg <= pc_reg[7:0];
        REG_PC_HI:  rdata_reg <= pc_reg[15:8];
        REG_RESULT: rdata_reg <= result_reg;
        default:    rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ---- logic/cabe_pkg.sv ----
// Shared constants and carriers for the ALU and branch execution core.
// Assumes a single 10 MHz clock and an outside register file and stack.
package cabe_pkg;

  // Status flag positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;

  // Values after reset
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] PC_RST    = 16'h0000;

  // Cycle counts
  localparam logic [2:0] CYC_ONE   = 3'h1;
  localparam logic [2:0] CYC_TWO   = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR  = 3'h4;

  // Register port offsets
  localparam logic [1:0] REG_FLAGS  = 2'h0;
  localparam logic [1:0] REG_PC_LO  = 2'h1;
  localparam logic [1:0] REG_PC_HI  = 2'h2;
  localparam logic [1:0] REG_RESULT = 2'h3;

  typedef enum logic [5:0] {
    OP_ADD, OP_ADD_CARRY, OP_WORD_PLUS_IMMEDIATE, OP_SUBTRACT, OP_MINUS_IMMEDIATE,
    OP_MINUS_WITH_BORROW, OP_MINUS_IMMEDIATE_BORROW, OP_WORD_MINUS_IMMEDIATE,
    OP_AND, OP_MASK_WITH_IMMEDIATE, OP_OR, OP_MERGE_IMMEDIATE_BITS, OP_EXCLUSIVE_OR_REGISTERS,
    OP_INVERT_BITS, OP_ARITH_INVERT, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_INCREMENT,
    OP_DECREMENT, OP_ZERO_SIGN_CHECK, OP_CLEAR, OP_FILL_ONES,
    OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL, OP_POINTER_CALL,
    OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT, OP_EQUAL_SKIP,
    OP_COMPARE_REGS, OP_COMPARE_REGS_CARRY, OP_COMPARE_IMMEDIATE,
    OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET, OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_EQUAL, OP_BRANCH_NOT_EQUAL,
    OP_BRANCH_CARRY_SET, OP_BRANCH_CARRY_CLEAR, OP_BRANCH_SAME_HIGHER, OP_BRANCH_LOWER,
    OP_BRANCH_MINUS, OP_BRANCH_PLUS, OP_BRANCH_SIGNED_AT_LEAST, OP_BRANCH_SIGNED_LESS,
    OP_BRANCH_HALFCARRY_SET, OP_BRANCH_HALFCARRY_CLEAR, OP_BRANCH_TFLAG_SET,
    OP_BRANCH_TFLAG_CLEAR, OP_BRANCH_OVERFLOW_SET, OP_BRANCH_OVERFLOW_CLEAR,
    OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY
  } cabe_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } cabe_state_t;

  typedef struct packed {
    cabe_op_t    op;
    logic [7:0]  a;
    logic [7:0]  b;
    logic [7:0]  imm;
    logic [2:0]  bsel;
    logic [11:0] offs;
    logic [15:0] word;
    logic [15:0] zptr;
    logic [15:0] stack;
    logic [7:0]  io;
    logic        long_next;
  } cabe_req_t;

  typedef struct packed {
    logic        wr_en;
    logic [7:0]  wr_data;
    logic        word_wr_en;
    logic [15:0] word_data;
    logic        io_wr_en;
    logic [7:0]  io_data;
    logic        push_en;
    logic [15:0] push_data;
    logic        pop_en;
  } cabe_res_t;

endpackage

// ---- bench/cabe_core_asserts.sv ----
// Port checker for the execution core.
// Assumes it is bound onto cabe_core, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module cabe_core_asserts (
  input wire logic                clk,
  input wire logic                sys_rst,
  input wire logic                req_valid,
  input wire cabe_pkg::cabe_req_t req,
  input wire logic                req_ready,
  input wire logic                done,
  input wire cabe_pkg::cabe_res_t res,
  input wire logic [15:0]         pc,
  input wire logic [7:0]          flags
);
  import cabe_pkg::*;
  logic go;
  assign go = req_valid && req_ready;
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_add_result: assert property (go && req.op == OP_ADD |=> res.wr_en && done
    && res.wr_data == 8'($past(req.a) + $past(req.b))) else $error("add result wrong");
  a_word_timing: assert property (go && req.op == OP_WORD_PLUS_IMMEDIATE |=> !done && !req_ready
    && res.word_data == 16'($past(req.word) + $past(req.imm[5:0])) ##1 done) else $error("word add wrong");
  a_logic_carry: assert property (go && req.op inside {OP_AND, OP_OR, OP_EXCLUSIVE_OR_REGISTERS} |=> done
    && flags[FL_C] == $past(flags[FL_C]) && !flags[FL_V]) else $error("logic flags wrong");
  a_ptr_jump: assert property (go && req.op == OP_POINTER_JUMP |=> pc == $past(req.zptr) && !done
    && flags == $past(flags) ##1 done) else $error("pointer jump wrong");
  a_ptr_call: assert property (go && req.op == OP_POINTER_CALL |=> pc == $past(req.zptr) && res.push_en
    ##1 !done ##1 done) else $error("pointer call wrong");
  a_return_time: assert property (go && req.op inside {OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT} |=> res.pop_en
    && pc == $past(req.stack) ##1 (!done)[*2] ##1 done) else $error("return timing wrong");
  a_io_set: assert property (go && req.op == OP_IO_BIT_SET |=> res.io_wr_en
    && res.io_data == ($past(req.io) | (8'h01 << $past(req.bsel))) ##1 done) else $error("io set wrong");
  a_shift_left: assert property (go && req.op == OP_SHIFT_LEFT_LOGICAL |=> res.wr_data == {$past(req.a[6:0]), 1'b0}
    && flags[FL_C] == $past(req.a[7]) && done) else $error("shift left wrong");
endmodule
bind cabe_core cabe_core_asserts cabe_core_asserts_i (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .done(done), .res(res), .pc(pc), .flags(flags));
`default_nettype wire

// ---- bench/test_cabe_core.sv ----
// Self-checking bench for the execution core.
// Assumes the core alone, its ports driven directly.
`timescale 1ns/10ps
`default_nettype none
module test_cabe_core;
  import cabe_pkg::*;
  logic        clk, sys_rst, req_valid, req_ready, done, reg_wr, reg_rd, t;
  logic [1:0]  reg_addr;
  logic [7:0]  flags, reg_wdata, reg_rdata, ef;
  logic [15:0] pc, epc, w;
  logic [31:0] seed, v;
  cabe_req_t   req, r;
  cabe_res_t   res, got;
  int          errors, tests_run;
  cabe_op_t    lo [15] = '{OP_AND, OP_OR, OP_EXCLUSIVE_OR_REGISTERS, OP_MASK_WITH_IMMEDIATE,
    OP_MERGE_IMMEDIATE_BITS, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_SIGN_CHECK,
    OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
    OP_CLEAR, OP_FILL_ONES, OP_INCREMENT, OP_DECREMENT};
  cabe_op_t    ao [6] = '{OP_ADD, OP_ADD_CARRY, OP_SUBTRACT, OP_COMPARE_REGS, OP_MINUS_IMMEDIATE,
    OP_COMPARE_IMMEDIATE};
  cabe_op_t    jo [6] = '{OP_RELATIVE_JUMP, OP_POINTER_JUMP, OP_RELATIVE_CALL, OP_POINTER_CALL,
    OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT};
  cabe_core cabe_core_i (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .done(done), .res(res), .pc(pc), .flags(flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  ////////////////////////////////////////
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] tgt(input logic [11:0] o);
    return epc + {{4{o[11]}}, o} + 16'h0001;
  endfunction
  function automatic logic [15:0] alu(input logic [7:0] a, b, f, input logic ci, sb);
    logic [8:0] y;
    y = sb ? {1'b0, a} - {1'b0, b} - 9'(ci) : {1'b0, a} + {1'b0, b} + 9'(ci);
    f[FL_C] = y[8];
    f[FL_Z] = y[7:0] == 8'h00;
    f[FL_N] = y[7];
    f[FL_V] = (a[7] ^ y[7]) & (sb ? a[7] ^ b[7] : !(a[7] ^ b[7]));
    f[FL_S] = y[7] ^ f[FL_V];
    f[FL_H] = sb ? {1'b0, a[3:0]} < {1'b0, b[3:0]} + 5'(ci) : {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci) > 5'h0f;
    return {y[7:0], f};
  endfunction
  function automatic logic [15:0] lop(input cabe_op_t o, input logic [7:0] a, b, k, f);
    logic [7:0] y;
    logic       c;
    c = f[FL_C];
    case (o)
      OP_AND: y = a & b;
      OP_OR: y = a | b;
      OP_EXCLUSIVE_OR_REGISTERS: y = a ^ b;
      OP_MASK_WITH_IMMEDIATE: y = a & k;
      OP_MERGE_IMMEDIATE_BITS, OP_SET_MASK_BITS: y = a | k;
      OP_CLEAR_MASK_BITS: y = a & (8'hff - k);
      OP_SHIFT_LEFT_LOGICAL: {c, y} = {a, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: {y, c} = {1'b0, a};
      OP_ROTATE_LEFT_CARRY: {c, y} = {a, f[FL_C]};
      OP_CLEAR: y = 8'h00;
      OP_INCREMENT: y = a + 8'h01;
      OP_DECREMENT: y = a - 8'h01;
      OP_FILL_ONES: return {8'hff, f};
      default: y = a;
    endcase
    f[FL_C] = c;
    f[FL_Z] = y == 8'h00;
    f[FL_N] = y[7];
    f[FL_V] = o >= OP_SHIFT_LEFT_LOGICAL ? y[7] ^ c : 1'b0;
    if (o == OP_INCREMENT) f[FL_V] = y == 8'h80;
    if (o == OP_DECREMENT) f[FL_V] = y == 8'h7f;
    if (o >= OP_SHIFT_LEFT_LOGICAL) f[FL_S] = f[FL_N] ^ f[FL_V];
    return {y, f};
  endfunction
  function automatic logic cond(input int j, input logic [7:0] f, input logic [2:0] s);
    int   ix [10] = '{0, FL_Z, FL_C, FL_C, FL_N, 0, FL_H, FL_T, FL_V, FL_I};
    logic b;
    b = j < 2 ? f[s] : j / 2 == 5 ? f[FL_N] ^ f[FL_V] : f[ix[j / 2]];
    return b == ((j % 2 == 0) ^ (j / 2 == 3 || j / 2 == 5));
  endfunction
  ////////////////////////////////////////
  task automatic chk(input string s, input logic [23:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", s, e, g);
      errors++;
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic rg(input logic wrt, input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wrt;
    reg_rd <= !wrt;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!wrt) chk("rdata", d, reg_rdata);
  endtask
  task automatic exec(input int n);
    int k;
    @(posedge clk);
    req <= r;
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1 got = res;
    for (k = 1; k < 9 && done !== 1'b1; k++) @(posedge clk) #1;
    chk("cycles", n, k);
    chk("pc", epc, pc);
    chk("flags", ef, flags);
    if (k > 8) results();
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {sys_rst, req_valid, reg_wr, reg_rd, reg_addr, reg_wdata, req, r} = '0;
    sys_rst = 1'b1;
    errors = 0;
    tests_run = 0;
    seed = 32'h000099f3;
    ef = 8'h3c;
    epc = 16'h0000;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    rg(1'b0, 2'h0, 8'h00);
    rg(1'b1, 2'h1, 8'h5a);
    rg(1'b0, 2'h1, 8'h00);
    rg(1'b1, 2'h0, ef);
    rg(1'b0, 2'h0, ef);
    $display("register test done");
    for (int i = 0; i < 40; i++) begin
      v = rnd();
      r = '0;
      r.a = i == 0 ? 8'h7f : v[7:0];
      r.b = i == 0 ? 8'h01 : v[15:8];
      r.op = ao[i % 6];
      r.imm = r.b;
      {w[7:0], ef} = alu(r.a, r.b, ef, i % 6 == 1 && ef[FL_C], i % 6 > 1);
      epc++;
      exec(1);
      chk("result", r.op inside {OP_COMPARE_REGS, OP_COMPARE_IMMEDIATE} ? 9'h000 : {1'b1, w[7:0]},
        {got.wr_en, got.wr_data});
    end
    for (int i = 0; i < 45; i++) begin
      v = rnd();
      r = '0;
      r.op = lo[i % 15];
      {r.a, r.b, r.imm} = v[23:0];
      {w[7:0], ef} = lop(r.op, r.a, r.b, r.imm, ef);
      epc++;
      exec(1);
      chk("logic", {1'b1, w[7:0]}, {got.wr_en, got.wr_data});
    end
    rg(1'b0, 2'h3, w[7:0]);
    $display("arithmetic and logic test done");
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      r = '0;
      r.op = OP_WORD_PLUS_IMMEDIATE;
      r.word = i == 0 ? 16'hffff : v[15:0];
      r.imm = i == 0 ? 8'h01 : {2'b00, v[21:16]};
      {t, w} = 17'(r.word) + 17'(r.imm[5:0]);
      {ef[FL_C], ef[FL_Z], ef[FL_N], ef[FL_V]} = {t, w == 16'h0000, w[15], !r.word[15] & w[15]};
      ef[FL_S] = ef[FL_N] ^ ef[FL_V];
      epc++;
      exec(2);
      chk("word", {1'b1, w}, {got.word_wr_en, got.word_data});
    end
    for (int i = OP_BRANCH_FLAG_SET; i <= OP_BRANCH_IRQ_OFF; i++) begin
      repeat (3) begin
        v = rnd();
        ef = v[7:0];
        rg(1'b1, 2'h0, ef);
        r = '0;
        r.op = cabe_op_t'(i);
        {r.bsel, r.offs} = v[26:12];
        t = cond(i - OP_BRANCH_FLAG_SET, ef, r.bsel);
        epc = t ? tgt(r.offs) : epc + 16'h0001;
        exec(t ? 2 : 1);
      end
    end
    $display("branch test done");
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      r = '0;
      r.op = jo[i];
      {r.zptr, r.stack} = v;
      r.offs = v[27:16];
      w = epc + 16'h0001;
      epc = i > 3 ? r.stack : i % 2 == 1 ? r.zptr : tgt(r.offs);
      ef[FL_I] = ef[FL_I] | (i == 5);
      exec(2 + i / 2);
      chk("push", i / 2 == 1 ? {1'b1, w} : 17'h00000, {got.push_en, got.push_data});
      chk("pop", i > 3, got.pop_en);
    end
    for (int i = 0; i < 30; i++) begin
      v = rnd();
      r = '0;
      {r.long_next, r.bsel, r.io, r.a} = v[19:0];
      r.b = v[0] ? v[7:0] : v[15:8];
      r.op = i % 5 == 0 ? OP_EQUAL_SKIP : cabe_op_t'(int'(OP_SKIP_REG_BIT_CLEAR) + i % 5 - 1);
      t = i % 5 == 0 ? r.a == r.b : (i % 5 < 3 ? r.b[r.bsel] : r.io[r.bsel]) == (i % 5 % 2 == 0);
      epc = epc + (t ? (r.long_next ? 16'h0003 : 16'h0002) : 16'h0001);
      exec(t ? 2 + int'(r.long_next) : 1);
    end
    for (int i = 0; i < 8; i++) begin
      v = rnd();
      r = '0;
      r.op = i[0] ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET;
      r.io = v[7:0];
      r.bsel = i[2:0];
      epc++;
      exec(2);
      w = {8'h00, r.io};
      w[i] = !i[0];
      chk("io", {1'b1, w[7:0]}, {got.io_wr_en, got.io_data});
    end
    rg(1'b0, 2'h2, epc[15:8]);
    $display("flow and bit test done");
    results();
  end
endmodule
`default_nettype wire
